// File: hw/sam_decode.sv
`timescale 1ns/1ns
`include "sam_defines.svh"
// Notes on behaviour
// [R1] address is word index plus byte selector
// [R2] top two bits select one of four banks
// [R3] external address drops bits twenty to 31
// [R4] sram answers from lowest address upward
// [R5] user memory base splits private from user
// [R6] one channel word below user base each
// [R7] trap area: per priority, group, two structures
// [R8] trap load/store opcodes take twelve cycles
// [R9] mask rom at top 128k of bank 3
// [R10] unprogrammed rom redirects to external rom
// [R11] boot entry two bytes below top
// [R12] peripherals reachable only by device access
// [R13] device opcodes 2ff0-2ff5 three cycles; move 62f4
// [R14] device access in peripheral range only
// [R15] external ram decoded from 81000000 upward; code decodes external from 80010000 upward, any non-sram non-rom address
// [R16] bank order follows signed address order
module sam_decode (
  input  wire logic                    sys_clk,
  input  wire logic                    reset_n,
  input  wire logic                    req_valid,
  input  wire logic [15:0]             req_opcode,
  input  wire logic                    req_dev,
  input  wire logic [31:0]             req_addr,
  input  wire logic                    rom_programmed,
  input  wire logic                    trap_low_pri,
  input  wire logic [1:0]              trap_group,
  output logic                         req_ready,
  output logic                         done,
  output logic [29:0]                  word_addr,
  output logic [1:0]                   byte_sel,
  output logic [1:0]                   bank_sel,
  output logic [19:0]                  ext_addr,
  output sam_pkg::sam_target_t         target,
  output logic                         private_area,
  output logic                         chan_area,
  output logic                         trap_area,
  output logic [31:0]                  trap_struct_addr,
  output logic                         boot_entry_hit,
  output logic [31:0]                  user_memory_base,
  output logic [31:0]                  boot_entry_addr,
  output logic [31:0]                  boot_jump_max
);

  sam_pkg::sam_state_t  state_r,  state_nxt;
  logic [3:0]           cnt_r,    cnt_nxt;
  logic [29:0]          word_r,   word_nxt;
  logic [1:0]           bsel_r,   bsel_nxt;
  logic [1:0]           bank_r,   bank_nxt;
  logic [19:0]          ext_r,    ext_nxt;
  sam_pkg::sam_target_t tgt_r,    tgt_nxt;
  logic                 priv_r,   priv_nxt;
  logic                 chan_r,   chan_nxt;
  logic                 trap_r,   trap_nxt;
  logic [31:0]          tsa_r,    tsa_nxt;
  logic                 boot_r,   boot_nxt;
  logic                 done_r,   done_nxt;

  logic                 is_dev_op;
  logic                 is_move;
  logic                 is_trap_op;
  logic [3:0]           op_cycles;
  logic signed [31:0]   sa;
  logic                 in_sram;
  logic                 in_extram;
  logic                 in_rom;
  logic                 in_peri;
  logic [31:0]          trap_off;

  // signed compares keep the map in signed address order
  assign sa        = $signed(req_addr);
  assign in_sram   = sa <= $signed(`SAM_SRAM_TOP);
  assign in_extram = sa >= $signed(`SAM_EXTRAM_BASE)
                     && sa <= $signed(`SAM_EXTRAM_TOP);
  assign in_peri   = sa >= $signed(`SAM_PERI_BASE)
                     && sa <= $signed(`SAM_PERI_TOP);
  assign in_rom    = sa >= $signed(`SAM_ROM_BASE);

  // [R13] device opcode class
  assign is_dev_op = (req_opcode >= `SAM_OP_DEVLB
                      && req_opcode <= `SAM_OP_DEVSW);
  assign is_move   = req_opcode == `SAM_OP_DEVMOVE;

  // [R8] trap structure opcodes
  assign is_trap_op = req_opcode == `SAM_OP_LDTRAPH
                      || req_opcode == `SAM_OP_LDTRAPPED
                      || req_opcode == `SAM_OP_STTRAPPED
                      || req_opcode == `SAM_OP_STTRAPH;

  // move length depends on the core; one cycle here, core stalls
  always_comb begin
    if (is_trap_op) begin
      op_cycles = `SAM_TRAP_CYC;
    end else if (is_dev_op) begin
      op_cycles = `SAM_DEV_CYC;
    end else begin
      op_cycles = 4'h1;
    end
  end

  // [R7] priority, group, structure select
  always_comb begin
    trap_off = `SAM_TRAP_BASE;
    if (trap_low_pri) begin
      trap_off = trap_off + `SAM_PRI_STRIDE;
    end
    trap_off = trap_off + ({30'h0, trap_group} * `SAM_GRP_STRIDE);
    if (req_opcode == `SAM_OP_LDTRAPPED
        || req_opcode == `SAM_OP_STTRAPPED) begin
      trap_off = trap_off + `SAM_TRAP_STRIDE;
    end
  end

  assign req_ready = state_r == sam_pkg::SAM_ST_IDLE;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    word_nxt  = word_r;
    bsel_nxt  = bsel_r;
    bank_nxt  = bank_r;
    ext_nxt   = ext_r;
    tgt_nxt   = tgt_r;
    priv_nxt  = priv_r;
    chan_nxt  = chan_r;
    trap_nxt  = trap_r;
    tsa_nxt   = tsa_r;
    boot_nxt  = boot_r;
    done_nxt  = 1'b0;
    case (state_r)
      sam_pkg::SAM_ST_IDLE: begin
        if (req_valid) begin
          // [R1] word address and byte selector
          word_nxt = req_addr[`SAM_WORD_MSB:`SAM_WORD_LSB];
          bsel_nxt = req_addr[`SAM_BSEL_MSB:0];
          // [R2] bank from top bits; [R16] values follow sign order
          case (req_addr[`SAM_BANK_MSB:`SAM_BANK_LSB])
            `SAM_BANK_B0: bank_nxt = 2'h0;
            `SAM_BANK_B1: bank_nxt = 2'h1;
            `SAM_BANK_B2: bank_nxt = 2'h2;
            `SAM_BANK_B3: bank_nxt = 2'h3;
            default:      bank_nxt = 2'h0;
          endcase
          // [R3] only low address bits leave the chip
          ext_nxt = req_addr[`SAM_EXT_MSB:0];
          // [R5] private area below the user base
          priv_nxt = sa < $signed(`SAM_USER_BASE);
          // [R6] channel state words
          chan_nxt = sa <= $signed(`SAM_CHAN_TOP);
          trap_nxt = sa >= $signed(`SAM_TRAP_BASE)
                     && sa <= $signed(`SAM_TRAP_TOP);
          // [R11] boot entry fetch
          boot_nxt = req_addr == `SAM_BOOT_ENTRY;
          tsa_nxt  = is_trap_op ? trap_off : 32'h0;
          // [R12] [R14] peripherals only via device class in range
          if ((is_dev_op || is_move) && in_peri) begin
            tgt_nxt = sam_pkg::SAM_TGT_PERI;
          // [R4] on-chip sram at the bottom
          end else if (in_sram) begin
            tgt_nxt = sam_pkg::SAM_TGT_SRAM;
          // [R9] [R10] mask rom or external rom
          end else if (in_rom) begin
            tgt_nxt = rom_programmed ? sam_pkg::SAM_TGT_ROM
                                     : sam_pkg::SAM_TGT_EXTROM;
          // [R15] [R14] external ram and other memory
          end else if (in_extram || !in_sram) begin
            tgt_nxt = sam_pkg::SAM_TGT_EXT;
          end else begin
            tgt_nxt = sam_pkg::SAM_TGT_NONE;
          end
          if (op_cycles == 4'h1) begin
            done_nxt = 1'b1;
          end else begin
            cnt_nxt   = op_cycles - 4'h1;
            state_nxt = sam_pkg::SAM_ST_BUSY;
          end
        end
      end
      sam_pkg::SAM_ST_BUSY: begin
        // [R8] [R13] hold for the instruction's cycles
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          done_nxt  = 1'b1;
          state_nxt = sam_pkg::SAM_ST_IDLE;
        end
      end
      default: state_nxt = sam_pkg::SAM_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r <= sam_pkg::SAM_ST_IDLE;
      cnt_r   <= 4'h0;
      word_r  <= 30'h0;
      bsel_r  <= 2'h0;
      bank_r  <= 2'h0;
      ext_r   <= 20'h0;
      tgt_r   <= sam_pkg::SAM_TGT_NONE;
      priv_r  <= 1'b0;
      chan_r  <= 1'b0;
      trap_r  <= 1'b0;
      tsa_r   <= 32'h0;
      boot_r  <= 1'b0;
      done_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      word_r  <= word_nxt;
      bsel_r  <= bsel_nxt;
      bank_r  <= bank_nxt;
      ext_r   <= ext_nxt;
      tgt_r   <= tgt_nxt;
      priv_r  <= priv_nxt;
      chan_r  <= chan_nxt;
      trap_r  <= trap_nxt;
      tsa_r   <= tsa_nxt;
      boot_r  <= boot_nxt;
      done_r  <= done_nxt;
    end
  end

  assign done             = done_r;
  assign word_addr        = word_r;
  assign byte_sel         = bsel_r;
  assign bank_sel         = bank_r;
  assign ext_addr         = ext_r;
  assign target           = tgt_r;
  assign private_area     = priv_r;
  assign chan_area        = chan_r;
  assign trap_area        = trap_r;
  assign trap_struct_addr = tsa_r;
  assign boot_entry_hit   = boot_r;
  // [R5] constant for the load-base instruction
  assign user_memory_base = `SAM_USER_BASE;
  // [R11] entry and backward jump reach
  assign boot_entry_addr  = `SAM_BOOT_ENTRY;
  assign boot_jump_max    = `SAM_BOOT_JUMP_MAX;

endmodule

// File: hw/sam_defines.svh
`ifndef SAM_DEFINES_SVH
`define SAM_DEFINES_SVH
`define SAM_ADDR_W        32
`define SAM_WORD_MSB      31
`define SAM_WORD_LSB      2
`define SAM_BSEL_MSB      1
`define SAM_EXT_MSB       19
`define SAM_BANK_MSB      31
`define SAM_BANK_LSB      30
`define SAM_BANK_B0       2'h2
`define SAM_BANK_B1       2'h3
`define SAM_BANK_B2       2'h0
`define SAM_BANK_B3       2'h1
`define SAM_LOWEST_ADDR   32'h80000000
`define SAM_HIGHEST_ADDR  32'h7fffffff
`define SAM_SRAM_TOP      32'h8000ffff
`define SAM_EXTRAM_BASE   32'h81000000
`define SAM_EXTRAM_TOP    32'hbfffffff
`define SAM_USER_BASE     32'h80000140
`define SAM_CHAN_BASE     32'h80000000
`define SAM_CHAN_TOP      32'h8000003f
`define SAM_TRAP_BASE     32'h80000040
`define SAM_TRAP_TOP      32'h8000013f
`define SAM_ROM_BASE      32'h7ffe0000
`define SAM_BOOT_ENTRY    32'h7ffffffe
`define SAM_BOOT_JUMP_MAX 32'h00000100
`define SAM_PERI_BASE     32'h00000000
`define SAM_PERI_TOP      32'h3fffffff
`define SAM_OP_DEVLB      16'h2ff0
`define SAM_OP_DEVSB      16'h2ff1
`define SAM_OP_DEVLS      16'h2ff2
`define SAM_OP_DEVSS      16'h2ff3
`define SAM_OP_DEVLW      16'h2ff4
`define SAM_OP_DEVSW      16'h2ff5
`define SAM_OP_DEVMOVE    16'h62f4
`define SAM_OP_LDTRAPH    16'h26fe
`define SAM_OP_LDTRAPPED  16'h2cf6
`define SAM_OP_STTRAPPED  16'h2cfb
`define SAM_OP_STTRAPH    16'h26ff
`define SAM_DEV_CYC       4'h3
`define SAM_TRAP_CYC      4'hc
`define SAM_TRAP_STRIDE   32'h00000010
`define SAM_GRP_STRIDE    32'h00000020
`define SAM_PRI_STRIDE    32'h00000080
`endif

// File: hw/sam_pkg.sv
package sam_pkg;
  typedef enum logic [2:0] {
    SAM_TGT_NONE,
    SAM_TGT_SRAM,
    SAM_TGT_EXT,
    SAM_TGT_ROM,
    SAM_TGT_EXTROM,
    SAM_TGT_PERI
  } sam_target_t;
  typedef enum {
    SAM_ST_IDLE,
    SAM_ST_BUSY
  } sam_state_t;
endpackage

// File: bench/sam_decode_assertions.sv
`timescale 1ns/1ns
module sam_decode_assertions (
  input wire logic                 sys_clk,
  input wire logic                 reset_n,
  input wire logic                 req_valid,
  input wire logic [15:0]          req_opcode,
  input wire logic [31:0]          req_addr,
  input wire logic                 rom_programmed,
  input wire logic                 req_ready,
  input wire logic                 done,
  input wire logic [29:0]          word_addr,
  input wire logic [1:0]           byte_sel,
  input wire logic [1:0]           bank_sel,
  input wire logic [19:0]          ext_addr,
  input wire sam_pkg::sam_target_t target
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire tk = req_valid && req_ready;
  wire dv = req_opcode[15:4] == 12'h2ff && req_opcode[3:0] < 4'h6;
  wire tp = req_opcode inside {16'h26fe, 16'h2cf6, 16'h2cfb, 16'h26ff};
  wire rom = req_addr >= 32'h7ffe0000 && !req_addr[31];
  sequence s_w2; !done [*2]; endsequence
  sequence s_w11; !done [*8] ##1 !done [*3]; endsequence
  a_dev_three: assert property (tk && dv |=> s_w2 ##1 done)
    else $error("device op latency wrong");
  a_trap_twelve: assert property (tk && tp |=> s_w11 ##1 done)
    else $error("trap op latency wrong");
  a_busy_refuse: assert property (tk && (dv || tp) |=> !req_ready)
    else $error("ready high while busy");
  a_word_split: assert property (tk |=> {word_addr, byte_sel} == $past(req_addr))
    else $error("word or byte split wrong");
  a_bank_map: assert property (tk |=>
    bank_sel == {~$past(req_addr[31]), $past(req_addr[30])})
    else $error("bank select wrong");
  a_ext_low: assert property (tk |=> ext_addr == $past(req_addr[19:0]))
    else $error("external address wrong");
  a_peri_dev: assert property (tk && dv && req_addr[31:30] == 2'h0
    |=> target == sam_pkg::SAM_TGT_PERI)
    else $error("device op missed peripheral");
  a_rom_off: assert property (tk && rom && !rom_programmed
    |=> target == sam_pkg::SAM_TGT_EXTROM)
    else $error("blank rom not redirected");
endmodule
bind sam_decode sam_decode_assertions u_chk (.sys_clk, .reset_n, .req_valid,
  .req_opcode, .req_addr, .rom_programmed, .req_ready, .done, .word_addr,
  .byte_sel, .bank_sel, .ext_addr, .target);

// File: bench/sam_core_model.sv
`timescale 1ns/1ns
module sam_core_model (
  input  wire logic   sys_clk,
  input  wire logic   req_ready,
  output logic        req_valid,
  output logic [15:0] req_opcode,
  output logic        req_dev,
  output logic [31:0] req_addr,
  output logic        rom_programmed,
  output logic        trap_low_pri,
  output logic [1:0]  trap_group,
  output logic        hang
);
  initial begin
    {req_valid, req_opcode, req_dev, req_addr} = '0;
    {rom_programmed, trap_low_pri, trap_group, hang} = '0;
  end
  // ready sampled at negedge so the take edge never races
  task automatic issue(input logic [51:0] n);
    logic rdy;
    int   k;
    req_valid <= 1'b1;
    {req_opcode, req_addr, rom_programmed, trap_low_pri, trap_group} <= n;
    req_dev <= n[51:40] == 12'h2ff;
    for (k = 0; k < 40; k++) begin
      @(negedge sys_clk);
      rdy = req_ready;
      @(posedge sys_clk);
      if (rdy === 1'b1) break;
    end
    if (k == 40) hang <= 1'b1;
  endtask
  task automatic idle();
    req_valid <= 1'b0;
  endtask
endmodule

// File: bench/system_address_map_decode_tb.sv
`timescale 1ns/1ns
module system_address_map_decode_tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        req_valid, req_dev, rom_programmed, trap_low_pri, hang;
  logic        req_ready, done, private_area, chan_area;
  logic        trap_area, boot_entry_hit;
  logic [1:0]  trap_group, byte_sel, bank_sel;
  logic [15:0] req_opcode;
  logic [19:0] ext_addr;
  logic [29:0] word_addr;
  logic [31:0] req_addr, trap_struct_addr, user_memory_base, a, r;
  logic [31:0] boot_entry_addr, boot_jump_max;
  logic [51:0] n;
  logic [51:0] notes[$];
  sam_pkg::sam_target_t target;
  int          errors = 0, checks_done = 0, seed = 14, i, j;
  logic [31:0] addrs[15] = '{32'h00001000, 32'h3ffffffc, 32'h80000000,
    32'h8000003c, 32'h80000040, 32'h8000013f, 32'h80000140, 32'h8000ffff,
    32'h80010000, 32'h81000000, 32'hc0000000, 32'h7ffdfffc, 32'h7ffe0000,
    32'h7ffffffe, 32'h7fffffff};
  logic [15:0] ops[12] = '{16'h2ff0, 16'h2ff1, 16'h2ff2, 16'h2ff3, 16'h2ff4,
    16'h2ff5, 16'h62f4, 16'h26fe, 16'h2cf6, 16'h2cfb, 16'h26ff, 16'h63f0};
  sam_core_model u_core (.sys_clk, .req_ready, .req_valid, .req_opcode,
    .req_dev, .req_addr, .rom_programmed, .trap_low_pri, .trap_group, .hang);
  sam_decode u_dut (.sys_clk, .reset_n, .req_valid, .req_opcode, .req_dev,
    .req_addr, .rom_programmed, .trap_low_pri, .trap_group, .req_ready, .done,
    .word_addr, .byte_sel, .bank_sel, .ext_addr, .target, .private_area,
    .chan_area, .trap_area, .trap_struct_addr, .boot_entry_hit,
    .user_memory_base, .boot_entry_addr, .boot_jump_max);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask
  function automatic sam_pkg::sam_target_t exp_tgt(logic [51:0] m);
    logic [31:0] x;
    x = m[35:4];
    if ((m[51:40] == 12'h2ff && m[39:36] < 4'h6 || m[51:36] == 16'h62f4)
        && x[31:30] == 2'h0) return sam_pkg::SAM_TGT_PERI;
    if (x[31:16] == 16'h8000) return sam_pkg::SAM_TGT_SRAM;
    if (x >= 32'h7ffe0000 && !x[31])
      return m[3] ? sam_pkg::SAM_TGT_ROM : sam_pkg::SAM_TGT_EXTROM;
    return sam_pkg::SAM_TGT_EXT;
  endfunction
  function automatic logic [31:0] exp_trap(logic [51:0] m);
    logic [15:0] o;
    o = m[51:36];
    if (!(o inside {16'h26fe, 16'h2cf6, 16'h2cfb, 16'h26ff})) return 32'h0;
    return 32'h80000040 + (m[2] ? 32'h80 : 32'h0) + {m[1:0], 5'h0}
      + ((o == 16'h2cf6 || o == 16'h2cfb) ? 32'h10 : 32'h0);
  endfunction
  task automatic send(input logic [15:0] o, input logic [31:0] x);
    r = $random(seed);
    notes.push_back({o, x, r[3:0]});
    u_core.issue({o, x, r[3:0]});
  endtask
  task automatic end_test(input string name);
    int k;
    u_core.idle();
    @(posedge sys_clk);
    for (k = 0; k < 40 && notes.size() != 0; k++) @(posedge sys_clk);
    check(notes.size() == 0, "missing done");
    $display("test %s ended", name);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge hang) begin
    errors++;
    finish_test();
  end
  always @(negedge sys_clk) begin
    if (reset_n === 1'b1 && done === 1'b1) begin
      if (notes.size() == 0) check(1'b0, "done without request");
      else begin
        n = notes.pop_front();
        a = n[35:4];
        check({word_addr, byte_sel} === a, "split");
        check(target === exp_tgt(n), "target");
        check(trap_struct_addr === exp_trap(n), "trap address");
        check({chan_area, trap_area, private_area, boot_entry_hit} ===
          {a[31:6] == 26'h2000000, a >= 32'h80000040 && a <= 32'h8000013f,
          a[31] && a < 32'h80000140, a == 32'h7ffffffe}, "areas");
      end
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(negedge sys_clk);
    check(target === sam_pkg::SAM_TGT_NONE && done === 1'b0, "reset");
    check(req_ready === 1'b1, "ready after reset");
    check({user_memory_base, boot_entry_addr, boot_jump_max} ===
      {32'h80000140, 32'h7ffffffe, 32'h00000100}, "constants");
    $display("test reset ended");
    @(posedge sys_clk);
    foreach (addrs[i]) send(16'h63f0, addrs[i]);
    end_test("map table");
    foreach (ops[i]) for (j = 0; j < 3; j++) send(ops[i], addrs[j*6+1]);
    end_test("opcode classes");
    for (i = 0; i < 40; i++) send(ops[$unsigned($random(seed)) % 12],
      $random(seed));
    end_test("random mix");
    finish_test();
  end
endmodule
